// ===== rtl/osmx_pkg.sv
package osmx_pkg;

  // ----------------------------------------
  // data path geometry
  // ----------------------------------------
  localparam int unsigned OSMX_DATA_W = 8;
  localparam int unsigned OSMX_ADDR_W = 7;
  localparam int unsigned OSMX_MSB    = OSMX_DATA_W - 1;

  // ----------------------------------------
  // destination select encoding
  // ----------------------------------------
  localparam logic OSMX_DEST_ACCUM = 1'h0;
  localparam logic OSMX_DEST_FILE  = 1'h1;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] OSMX_ACCUM_RST = 8'h00;
  localparam logic       OSMX_FLAG_RST  = 1'h0;
  localparam logic       OSMX_PULSE_RST = 1'h0;

  // ----------------------------------------
  // operation codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    OSMX_OP_OR_ACCUM_INTO_FILE    = 2'h0,
    OSMX_OP_SHIFT_LEFT_ZERO_FILL  = 2'h1,
    OSMX_OP_SHIFT_RIGHT_ZERO_FILL = 2'h3,
    OSMX_OP_COPY_REGISTER         = 2'h2
  } osmx_op_t;

endpackage

// ===== rtl/osmx_result_unit.sv
module osmx_result_unit
  import osmx_pkg::*;
#(
  parameter int unsigned DATA_W = OSMX_DATA_W
)
(
  // operands
  input  wire logic [DATA_W-1:0] accumIn,
  input  wire logic [DATA_W-1:0] operandIn,
  input  wire osmx_op_t          opIn,
  // result
  output logic      [DATA_W-1:0] resultOut,
  output logic                   carryOut,
  output logic                   carryValid,
  output logic                   zeroOut
);

  wire [DATA_W-1:0] orValue    = accumIn | operandIn;
  wire [DATA_W-1:0] leftValue  = {operandIn[DATA_W-2:0], 1'h0};
  wire [DATA_W-1:0] rightValue = {1'h0, operandIn[DATA_W-1:1]};
  wire              isLeft     = (opIn == OSMX_OP_SHIFT_LEFT_ZERO_FILL);
  wire              isRight    = (opIn == OSMX_OP_SHIFT_RIGHT_ZERO_FILL);

  always_comb
  begin
    unique case (opIn)
      OSMX_OP_OR_ACCUM_INTO_FILE:    resultOut = orValue;
      OSMX_OP_SHIFT_LEFT_ZERO_FILL:  resultOut = leftValue;
      OSMX_OP_SHIFT_RIGHT_ZERO_FILL: resultOut = rightValue;
      OSMX_OP_COPY_REGISTER:         resultOut = operandIn;
    endcase
  end

  // carry comes from the bit that falls off the end; or and move leave it alone
  assign carryValid = isLeft | isRight;
  assign carryOut   = isLeft ? operandIn[DATA_W-1] : operandIn[0];
  assign zeroOut    = (resultOut == '0);

endmodule

// ===== rtl/osmx_exec_slice.sv
// Notes on behaviour
// - or: accumulator OR operand register, zero flag updated from result.
// - destination bit 0 writes accumulator, 1 writes back to operand register.
// - move copies operand register value unchanged to chosen destination.
// - left shift: operand bits 6..0 to result 7..1, bit 7 to carry.
// - left shift forces result bit 0 to zero.
// - right shift: operand bits 7..1 to result 6..0, bit 0 to carry.
// - right shift forces result bit 7 to zero.
module osmx_exec_slice
  import osmx_pkg::*;
#(
  parameter int unsigned DATA_W = OSMX_DATA_W,
  parameter int unsigned ADDR_W = OSMX_ADDR_W
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // instruction issue
  input  wire logic              execValid,
  input  wire osmx_op_t          execOp,
  input  wire logic              destSelect,
  input  wire logic [ADDR_W-1:0] fileAddr,
  // operand read port
  output logic      [ADDR_W-1:0] fileReadAddr,
  input  wire logic [DATA_W-1:0] fileReadData,
  // operand write port
  output logic                   fileWriteEn,
  output logic      [ADDR_W-1:0] fileWriteAddr,
  output logic      [DATA_W-1:0] fileWriteData,
  // accumulator and flags
  output logic      [DATA_W-1:0] accumOut,
  output logic                   carryFlag,
  output logic                   zeroFlag,
  output logic                   execDone
);

  // ----------------------------------------
  // combinational result
  // ----------------------------------------
  logic [DATA_W-1:0] resultValue;
  logic              carryValue;
  logic              carryTouched;
  logic              zeroValue;

  // the read address is a straight copy so the operand arrives in the same cycle
  assign fileReadAddr = fileAddr;

  osmx_result_unit #(
    .DATA_W (DATA_W)
  ) resultUnit (
    .accumIn    (accumOut),
    .operandIn  (fileReadData),
    .opIn       (execOp),
    .resultOut  (resultValue),
    .carryOut   (carryValue),
    .carryValid (carryTouched),
    .zeroOut    (zeroValue)
  );

  // ----------------------------------------
  // destination decode
  // ----------------------------------------
  // the destination bit only counts while an instruction is issued, so idle
  // cycles leave both the accumulator and the operand register alone
  wire toAccum = execValid & (destSelect == OSMX_DEST_ACCUM);
  wire toFile  = execValid & (destSelect == OSMX_DEST_FILE);

  // ----------------------------------------
  // flag update strobes
  // ----------------------------------------
  // carry belongs to the shifts alone; zero follows every one of the four
  wire carryLoad = execValid & carryTouched;
  wire zeroLoad  = execValid;

  // ----------------------------------------
  // architectural state
  // ----------------------------------------
  logic [DATA_W-1:0] accum_reg;
  logic [DATA_W-1:0] accum_next;
  logic              carry_reg;
  logic              carry_next;
  logic              zero_reg;
  logic              zero_next;

  assign accum_next = toAccum   ? resultValue : accum_reg;
  assign carry_next = carryLoad ? carryValue  : carry_reg;
  assign zero_next  = zeroLoad  ? zeroValue   : zero_reg;

  // ----------------------------------------
  // write-back state
  // ----------------------------------------
  logic              wrEn_reg;
  logic              wrEn_next;
  logic [ADDR_W-1:0] wrAddr_reg;
  logic [ADDR_W-1:0] wrAddr_next;
  logic [DATA_W-1:0] wrData_reg;
  logic [DATA_W-1:0] wrData_next;
  logic              done_reg;
  logic              done_next;

  // address and data are captured every cycle and qualified by the enable
  // alone, which keeps a load mux off their flops
  assign wrEn_next   = toFile;
  assign wrAddr_next = fileAddr;
  assign wrData_next = resultValue;
  assign done_next   = execValid;

  // ----------------------------------------
  // accumulator
  // ----------------------------------------
  // accumulator and flags commit on the edge that takes the instruction, so a back to
  // back issue sees the new accumulator without any bypass
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      accum_reg <= DATA_W'(OSMX_ACCUM_RST);
    end
    else
    begin
      accum_reg <= accum_next;
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      carry_reg <= OSMX_FLAG_RST;
    end
    else
    begin
      carry_reg <= carry_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      zero_reg <= OSMX_FLAG_RST;
    end
    else
    begin
      zero_reg <= zero_next;
    end
  end

  // ----------------------------------------
  // operand write port
  // ----------------------------------------
  // the write-back lands one cycle after issue; a file that is read back to
  // back at the same address has to forward it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrEn_reg <= OSMX_PULSE_RST;
    end
    else
    begin
      wrEn_reg <= wrEn_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrAddr_reg <= '0;
    end
    else
    begin
      wrAddr_reg <= wrAddr_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrData_reg <= '0;
    end
    else
    begin
      wrData_reg <= wrData_next;
    end
  end

  // ----------------------------------------
  // completion strobe
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      done_reg <= OSMX_PULSE_RST;
    end
    else
    begin
      done_reg <= done_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every output but the read address comes straight from a flop
  assign accumOut      = accum_reg;
  assign carryFlag     = carry_reg;
  assign zeroFlag      = zero_reg;
  assign fileWriteEn   = wrEn_reg;
  assign fileWriteAddr = wrAddr_reg;
  assign fileWriteData = wrData_reg;
  assign execDone      = done_reg;

endmodule

// ===== bench/osmx_exec_slice_asserts.sv
module osmx_exec_slice_asserts
  import osmx_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // issue
  input wire logic       execValid,
  input wire osmx_op_t   execOp,
  input wire logic       destSelect,
  input wire logic [6:0] fileAddr,
  // file ports
  input wire logic [6:0] fileReadAddr,
  input wire logic [7:0] fileReadData,
  input wire logic       fileWriteEn,
  input wire logic [6:0] fileWriteAddr,
  input wire logic [7:0] fileWriteData,
  // results
  input wire logic [7:0] accumOut,
  input wire logic       carryFlag,
  input wire logic       zeroFlag,
  input wire logic       execDone
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_done_one_cycle: assert property (execValid |=> execDone)
    else $error("done pulse missing");
  a_file_write: assert property (
    execValid && destSelect |=> fileWriteEn && $stable(accumOut)
    && fileWriteAddr == $past(fileAddr)) else $error("file write wrong");
  a_or_accum: assert property (
    execValid && execOp == OSMX_OP_OR_ACCUM_INTO_FILE && !destSelect
    |=> accumOut == ($past(accumOut) | $past(fileReadData))) else $error("or wrong");
  a_copy_value: assert property (
    execValid && execOp == OSMX_OP_COPY_REGISTER && !destSelect
    |=> accumOut == $past(fileReadData)) else $error("copy wrong");
  a_left_shift: assert property (
    execValid && execOp == OSMX_OP_SHIFT_LEFT_ZERO_FILL && destSelect
    |=> fileWriteData == {$past(fileReadData[6:0]), 1'h0} && carryFlag == $past(fileReadData[7]))
    else $error("left shift wrong");
  a_right_shift: assert property (
    execValid && execOp == OSMX_OP_SHIFT_RIGHT_ZERO_FILL && destSelect
    |=> fileWriteData == {1'h0, $past(fileReadData[7:1])} && carryFlag == $past(fileReadData[0]))
    else $error("right shift wrong");
  a_carry_kept: assert property (execValid && !execOp[0] |=> $stable(carryFlag))
    else $error("carry changed");
  a_zero_flag: assert property (
    execValid |=> zeroFlag == ((fileWriteEn ? fileWriteData : accumOut) == 8'h00))
    else $error("zero flag wrong");
  a_idle_quiet: assert property (
    !execValid |=> !fileWriteEn && !execDone && $stable(accumOut)
    && $stable(carryFlag) && $stable(zeroFlag)) else $error("idle cycle acted");
  a_read_addr: assert property (fileReadAddr == fileAddr)
    else $error("read address wrong");
  cover property (execValid && execOp == OSMX_OP_COPY_REGISTER && destSelect);
  cover property (execValid && execOp == OSMX_OP_SHIFT_LEFT_ZERO_FILL && destSelect);
  cover property (execValid && execOp == OSMX_OP_SHIFT_RIGHT_ZERO_FILL && !destSelect);
  cover property (execValid && execOp == OSMX_OP_OR_ACCUM_INTO_FILE && destSelect);
  cover property (execValid ##1 execValid);
endmodule
bind osmx_exec_slice osmx_exec_slice_asserts i_osmx_exec_slice_asserts (
  .clk           (clk),
  .reset_n       (reset_n),
  .execValid     (execValid),
  .execOp        (execOp),
  .destSelect    (destSelect),
  .fileAddr      (fileAddr),
  .fileReadAddr  (fileReadAddr),
  .fileReadData  (fileReadData),
  .fileWriteEn   (fileWriteEn),
  .fileWriteAddr (fileWriteAddr),
  .fileWriteData (fileWriteData),
  .accumOut      (accumOut),
  .carryFlag     (carryFlag),
  .zeroFlag      (zeroFlag),
  .execDone      (execDone)
);

// ===== bench/tb_osmx_exec_slice.sv
module tb_osmx_exec_slice
  import osmx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk          = 1'h0;
  logic       reset_n      = 1'h0;
  logic       execValid    = 1'h0;
  osmx_op_t   execOp       = OSMX_OP_COPY_REGISTER;
  logic       destSelect   = 1'h0;
  logic [6:0] fileAddr     = 7'h00;
  logic [7:0] fileReadData = 8'h00;
  logic       fileWriteEn;
  logic       carryFlag;
  logic       zeroFlag;
  logic       execDone;
  logic [6:0] fileReadAddr;
  logic [6:0] fileWriteAddr;
  logic [7:0] fileWriteData;
  logic [7:0] accumOut;
  logic [7:0] acc          = 8'h00;
  logic       cy           = 1'h0;
  int         fail_count   = 0;
  int         checks_done  = 0;
  always #25 clk = ~clk;
  osmx_exec_slice i_osmx_exec_slice (
    .clk           (clk),
    .reset_n       (reset_n),
    .execValid     (execValid),
    .execOp        (execOp),
    .destSelect    (destSelect),
    .fileAddr      (fileAddr),
    .fileReadAddr  (fileReadAddr),
    .fileReadData  (fileReadData),
    .fileWriteEn   (fileWriteEn),
    .fileWriteAddr (fileWriteAddr),
    .fileWriteData (fileWriteData),
    .accumOut      (accumOut),
    .carryFlag     (carryFlag),
    .zeroFlag      (zeroFlag),
    .execDone      (execDone)
  );
  task chk(string n, logic [7:0] s, logic [7:0] e);
    checks_done++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // expected result kept here, independent of the design
  task run(osmx_op_t op, logic d, logic [6:0] a, logic [7:0] f);
    logic [7:0] r;
    case (op)
      OSMX_OP_OR_ACCUM_INTO_FILE:    r = acc | f;
      OSMX_OP_SHIFT_LEFT_ZERO_FILL:  {cy, r} = {f, 1'h0};
      OSMX_OP_SHIFT_RIGHT_ZERO_FILL: {r, cy} = {1'h0, f};
      default:                       r = f;
    endcase
    if (!d)
      acc = r;
    @(posedge clk);
    execValid    <= 1'h1;
    execOp       <= op;
    destSelect   <= d;
    fileAddr     <= a;
    fileReadData <= f;
    #1;
    chk("read addr", fileReadAddr, a);
    @(posedge clk);
    execValid <= 1'h0;
    #1;
    chk("accum", accumOut, acc);
    chk("write enable", fileWriteEn, d);
    if (d)
    begin
      chk("write data", fileWriteData, r);
      chk("write addr", fileWriteAddr, a);
    end
    chk("carry", carryFlag, cy);
    chk("zero", zeroFlag, r == 8'h00);
    chk("done", execDone, 1'h1);
  endtask
  task t_copy;
    run(OSMX_OP_COPY_REGISTER, 1'h0, 7'h05, 8'h5a);
    run(OSMX_OP_COPY_REGISTER, 1'h1, 7'h7f, 8'h00);
    $display("test copy done");
  endtask
  task t_or;
    run(OSMX_OP_OR_ACCUM_INTO_FILE, 1'h0, 7'h11, 8'h81);
    run(OSMX_OP_OR_ACCUM_INTO_FILE, 1'h1, 7'h00, 8'h24);
    $display("test or done");
  endtask
  // carry is left set before the zero-fill checks, so a fed-back carry shows
  task t_shift;
    run(OSMX_OP_SHIFT_LEFT_ZERO_FILL, 1'h1, 7'h05, 8'h81);
    run(OSMX_OP_COPY_REGISTER, 1'h1, 7'h10, 8'h00);
    run(OSMX_OP_SHIFT_LEFT_ZERO_FILL, 1'h0, 7'h01, 8'h80);
    run(OSMX_OP_SHIFT_RIGHT_ZERO_FILL, 1'h0, 7'h06, 8'h01);
    run(OSMX_OP_OR_ACCUM_INTO_FILE, 1'h0, 7'h02, 8'h00);
    run(OSMX_OP_SHIFT_RIGHT_ZERO_FILL, 1'h1, 7'h7e, 8'h80);
    $display("test shift done");
  endtask
  task t_back_to_back;
    @(posedge clk);
    execValid    <= 1'h1;
    execOp       <= OSMX_OP_SHIFT_LEFT_ZERO_FILL;
    destSelect   <= OSMX_DEST_ACCUM;
    fileAddr     <= 7'h12;
    fileReadData <= 8'h43;
    @(posedge clk);
    execOp       <= OSMX_OP_OR_ACCUM_INTO_FILE;
    fileReadData <= 8'h30;
    #1;
    chk("b2b first accum", accumOut, 8'h86);
    @(posedge clk);
    execValid <= 1'h0;
    #1;
    chk("b2b second accum", accumOut, 8'hb6);
    chk("b2b carry", carryFlag, 1'h0);
    chk("b2b zero", zeroFlag, 1'h0);
    chk("b2b done", execDone, 1'h1);
    acc = 8'hb6;
    cy  = 1'h0;
    $display("test back to back done");
  endtask
  task t_reset;
    run(OSMX_OP_SHIFT_LEFT_ZERO_FILL, 1'h1, 7'h33, 8'hc1);
    @(posedge clk);
    reset_n <= 1'h0;
    @(posedge clk);
    #1;
    chk("reset accum", accumOut, 8'h00);
    chk("reset carry", carryFlag, 1'h0);
    chk("reset zero", zeroFlag, 1'h0);
    chk("reset write enable", fileWriteEn, 1'h0);
    chk("reset write addr", fileWriteAddr, 7'h00);
    chk("reset write data", fileWriteData, 8'h00);
    chk("reset done", execDone, 1'h0);
    @(posedge clk);
    reset_n <= 1'h1;
    acc = 8'h00;
    cy  = 1'h0;
    run(OSMX_OP_OR_ACCUM_INTO_FILE, 1'h0, 7'h01, 8'h00);
    $display("test reset done");
  endtask
  task summarize;
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'h1;
    #1;
    chk("reset accum", accumOut, 8'h00);
    t_copy;
    t_or;
    t_shift;
    t_back_to_back;
    t_reset;
    summarize;
  end
  // tests need about thirty-five cycles
  initial
  begin
    #20000;
    fail_count++;
    summarize;
  end
endmodule
